// *** tcs_defs.svh ***
`ifndef TCS_DEFS_SVH
`define TCS_DEFS_SVH

// register word addresses on the plain register port
`define TCS_ADDR_CTRL 4'h0
`define TCS_ADDR_CFG 4'h1
`define TCS_ADDR_IN_PERIOD 4'h2
`define TCS_ADDR_OUT_PERIOD 4'h3
`define TCS_ADDR_IN_COUNT 4'h4
`define TCS_ADDR_OUT_COUNT 4'h5
`define TCS_ADDR_LIST_LEN 4'h6
`define TCS_ADDR_STATUS 4'h7
`define TCS_ADDR_IN_DONE 4'h8
`define TCS_ADDR_OUT_DONE 4'h9

// control word: write-one command pulses
`define TCS_CTRL_IN_START 0
`define TCS_CTRL_IN_STOP 1
`define TCS_CTRL_OUT_START 2
`define TCS_CTRL_OUT_STOP 3

// configuration word fields
`define TCS_CFG_IN_MODE_LSB 0
`define TCS_CFG_OUT_MODE_LSB 2
`define TCS_CFG_IN_EXT 4
`define TCS_CFG_OUT_EXT 5
`define TCS_CFG_IN_LIST 6
`define TCS_CFG_RESET 7'h00

// status word fields
`define TCS_STAT_IN_RUN 0
`define TCS_STAT_OUT_RUN 1
`define TCS_STAT_IN_ARM 2
`define TCS_STAT_OUT_ARM 3

// reset values of the timing registers
`define TCS_PERIOD_RESET 32'h0000_0064
`define TCS_COUNT_RESET 32'h0000_0000
`define TCS_LIST_LEN_RESET 4'h1

// timing: processor clock, sync delay and the far side's setup figure
`define TCS_CLK_PERIOD_NS 10
`define TCS_SYNC_DELAY_CYC 4
`define TCS_TRIG_CLK_SETUP_NS 50
`define TCS_TRIG_CLK_SETUP_CYC ((`TCS_TRIG_CLK_SETUP_NS + `TCS_CLK_PERIOD_NS - 1) / `TCS_CLK_PERIOD_NS)

`endif

// *** tcs_pkg.sv ***
package tcs_pkg;

  // hardware trigger mode select; off is the reset choice
  typedef enum logic [1:0] {
    TCS_TRIG_OFF,
    TCS_TRIG_SINGLE,
    TCS_TRIG_GATED
  } tcs_trig_mode_type;

  // sequencer state, one per direction
  typedef enum logic [1:0] {
    TCS_IDLE,
    TCS_ARM,
    TCS_RUN
  } tcs_state_type;

  // software configuration
  typedef struct packed {
    logic in_list;
    logic out_ext;
    logic in_ext;
    tcs_trig_mode_type out_mode;
    tcs_trig_mode_type in_mode;
  } tcs_cfg_type;

  // synchronised view of one outside signal
  typedef struct packed {
    logic level;
    logic change;
    logic rise;
  } tcs_sync_type;

endpackage : tcs_pkg

// *** tcs_sync.sv ***
`timescale 1ns/100ps
`default_nettype none

// three-stage synchroniser; a change counts once stages two and three agree
module tcs_sync (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_async,
  output tcs_pkg::tcs_sync_type o_sync
);

  logic s1_q; // metastability catcher, read only by s2_q
  logic s2_q;
  logic s3_q;
  logic stable_q; // accepted level
  tcs_pkg::tcs_sync_type out_q;

  // shift chain; the first stage is never looked at by logic
  always_ff @(posedge i_ref_clk) begin
    s1_q <= i_async;
    s2_q <= s1_q;
    s3_q <= s2_q;
  end

  // accept a new level when two later stages agree
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      stable_q <= 1'b0;
      out_q <= '0;
    end else begin
      out_q.change <= 1'b0;
      out_q.rise <= 1'b0;
      if (s2_q == s3_q && s3_q != stable_q) begin
        stable_q <= s3_q;
        out_q.change <= 1'b1;
        out_q.rise <= s3_q;
      end
      out_q.level <= stable_q;
    end
  end

  assign o_sync = out_q;

  // a held rise reaches the core four clocks after the pin
  sequence s_pin_rise;
    $rose(i_async) ##1 i_async [*3];
  endsequence
  property p_sync_delay;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      s_pin_rise |-> ##1 o_sync.rise;
  endproperty
  a_sync_delay: assert property (p_sync_delay)
    else $error("rise not seen four clocks after pin");

endmodule : tcs_sync

`default_nettype wire

// *** tcs_trigger_clock_sequencer.sv ***
// Contract
// - gated output: update while high, halt low
// - gated output with external clock: any width
// - all output channels update together
// - first external input clock edge discarded
// - second input edge accepted 50 ns later
// - first trigger rise converts, no lost edge
// - trigger plus external clock: 1-2 cycles
// - retrigger restarts after 1-2 clock cycles
// - internal timer realigned to trigger edge
// - output updates on first clock after trigger
// - sync delay is four processor clocks
// - single-shot waits high, runs to count/stop
// - gated input stops at list/channel boundary
// - trigger mode off, single, gated; reset off
`include "tcs_defs.svh"
`timescale 1ns/100ps
`default_nettype none

module tcs_trigger_clock_sequencer (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_in_ext_clk,
  input wire logic i_out_ext_clk,
  input wire logic i_in_trig,
  input wire logic i_out_trig,
  input wire logic [3:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  output logic o_in_sample,
  output logic [3:0] o_in_chan,
  output logic o_out_update
);

  // link side: one toggle per external clock edge, each on its own clock
  logic [1:0] ext_clk;
  logic [1:0] ext_tog;
  tcs_pkg::tcs_sync_type [1:0] ext_sync;
  assign ext_clk = {i_out_ext_clk, i_in_ext_clk};

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_link
      logic [1:0] rst_sync_q; // reset level carried into the link domain
      logic tog_q;
      // two flops for the reset level
      always_ff @(posedge ext_clk[g]) begin
        rst_sync_q <= {rst_sync_q[0], i_rst_n};
      end
      // a toggle survives edges closer than the core can sample
      always_ff @(posedge ext_clk[g]) begin
        if (!rst_sync_q[1]) begin
          tog_q <= 1'b0;
        end else begin
          tog_q <= ~tog_q;
        end
      end
      assign ext_tog[g] = tog_q;
      tcs_sync u_clk_sync (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .i_async(ext_tog[g]),
        .o_sync(ext_sync[g])
      );
    end
  endgenerate

  // trigger pins
  tcs_pkg::tcs_sync_type in_trig;
  tcs_pkg::tcs_sync_type out_trig;
  tcs_sync u_in_trig (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_async(i_in_trig),
    .o_sync(in_trig)
  );
  tcs_sync u_out_trig (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_async(i_out_trig),
    .o_sync(out_trig)
  );

  // software state
  tcs_pkg::tcs_cfg_type cfg_q;
  logic [31:0] in_period_q;
  logic [31:0] out_period_q;
  logic [31:0] in_count_q;
  logic [31:0] out_count_q;
  logic [3:0] list_len_q;
  logic [31:0] rdata_q;
  logic wr_ctrl;
  assign wr_ctrl = i_wr && i_addr == `TCS_ADDR_CTRL;

  // sequencer state
  tcs_pkg::tcs_state_type in_st_q;
  tcs_pkg::tcs_state_type out_st_q;
  logic [31:0] in_timer_q;
  logic [31:0] out_timer_q;
  logic [31:0] in_done_q;
  logic [31:0] out_done_q;
  logic in_first_q; // external input edge still to be discarded
  logic [3:0] in_chan_q;
  logic in_sample_q;
  logic out_update_q;

  // register writes; trigger modes come out of reset as off
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      cfg_q <= `TCS_CFG_RESET;
      in_period_q <= `TCS_PERIOD_RESET;
      out_period_q <= `TCS_PERIOD_RESET;
      in_count_q <= `TCS_COUNT_RESET;
      out_count_q <= `TCS_COUNT_RESET;
      list_len_q <= `TCS_LIST_LEN_RESET;
    end else if (i_wr) begin
      case (i_addr)
        `TCS_ADDR_CFG: cfg_q <= i_wdata[6:0];
        `TCS_ADDR_IN_PERIOD: in_period_q <= i_wdata;
        `TCS_ADDR_OUT_PERIOD: out_period_q <= i_wdata;
        `TCS_ADDR_IN_COUNT: in_count_q <= i_wdata;
        `TCS_ADDR_OUT_COUNT: out_count_q <= i_wdata;
        `TCS_ADDR_LIST_LEN: list_len_q <= i_wdata[3:0];
        default: ; // control pulses and read-only words
      endcase
    end
  end

  // read data, valid only in the cycle after the strobe
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n || !i_rd) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      case (i_addr)
        `TCS_ADDR_CFG: rdata_q <= {25'h000_0000, cfg_q};
        `TCS_ADDR_IN_PERIOD: rdata_q <= in_period_q;
        `TCS_ADDR_OUT_PERIOD: rdata_q <= out_period_q;
        `TCS_ADDR_IN_COUNT: rdata_q <= in_count_q;
        `TCS_ADDR_OUT_COUNT: rdata_q <= out_count_q;
        `TCS_ADDR_LIST_LEN: rdata_q <= {28'h000_0000, list_len_q};
        `TCS_ADDR_STATUS: rdata_q <= {28'h000_0000,
          out_st_q == tcs_pkg::TCS_ARM, in_st_q == tcs_pkg::TCS_ARM,
          out_st_q == tcs_pkg::TCS_RUN, in_st_q == tcs_pkg::TCS_RUN};
        `TCS_ADDR_IN_DONE: rdata_q <= in_done_q;
        `TCS_ADDR_OUT_DONE: rdata_q <= out_done_q;
        default: rdata_q <= 32'h0000_0000; // unmapped reads zero
      endcase
    end
  end

  // ---------------- input side ----------------
  logic in_gated;
  logic in_boundary;
  logic in_paused;
  logic in_fire;
  logic in_last;
  assign in_gated = cfg_q.in_mode == tcs_pkg::TCS_TRIG_GATED;
  // list clocking pauses only between lists, single clocking per channel
  assign in_boundary = !cfg_q.in_list || in_chan_q == 4'h0;
  assign in_paused = in_gated && in_boundary && !in_trig.level;
  assign in_last = in_count_q != 32'h0000_0000 &&
    in_done_q + 32'h0000_0001 == in_count_q;

  // when a sample is taken
  always_comb begin
    in_fire = 1'b0;
    if (in_st_q == tcs_pkg::TCS_RUN) begin
      if (cfg_q.in_ext) begin
        // the outside clock paces; the trigger only gates
        in_fire = ext_sync[0].change && !in_first_q &&
          !in_paused;
      end else begin
        // a trigger rise out of a pause fires at once
        in_fire = (in_gated && in_boundary && in_trig.rise) ||
          (!in_paused && in_timer_q == 32'h0000_0000);
      end
    end else if (in_st_q == tcs_pkg::TCS_ARM && !cfg_q.in_ext) begin
      in_fire = in_trig.level;
    end
  end

  // input sequencer state
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      in_st_q <= tcs_pkg::TCS_IDLE;
    end else if (wr_ctrl && i_wdata[`TCS_CTRL_IN_STOP]) begin
      in_st_q <= tcs_pkg::TCS_IDLE;
    end else if (wr_ctrl && i_wdata[`TCS_CTRL_IN_START]) begin
      in_st_q <= cfg_q.in_mode == tcs_pkg::TCS_TRIG_SINGLE ?
        tcs_pkg::TCS_ARM : tcs_pkg::TCS_RUN;
    end else if (in_fire && in_last) begin
      in_st_q <= tcs_pkg::TCS_IDLE;
    end else if (in_st_q == tcs_pkg::TCS_ARM && in_trig.level) begin
      in_st_q <= tcs_pkg::TCS_RUN;
    end
  end

  // internal timer, reloaded on every sample so a trigger realigns it
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      in_timer_q <= 32'h0000_0000;
    end else if (in_fire) begin
      in_timer_q <= in_period_q - 32'h0000_0001;
    end else if (in_timer_q != 32'h0000_0000 && !in_paused) begin
      in_timer_q <= in_timer_q - 32'h0000_0001;
    end
  end

  // first outside edge after start only synchronises
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      in_first_q <= 1'b0;
    end else if (wr_ctrl && i_wdata[`TCS_CTRL_IN_START]) begin
      in_first_q <= cfg_q.in_ext;
    end else if (ext_sync[0].change) begin
      in_first_q <= 1'b0;
    end
  end

  // sample count and channel position
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      in_done_q <= 32'h0000_0000;
      in_chan_q <= 4'h0;
    end else if (wr_ctrl && i_wdata[`TCS_CTRL_IN_START]) begin
      in_done_q <= 32'h0000_0000;
      in_chan_q <= 4'h0;
    end else if (in_fire) begin
      in_done_q <= in_done_q + 32'h0000_0001;
      in_chan_q <= in_chan_q + 4'h1 >= list_len_q ? 4'h0 :
        in_chan_q + 4'h1;
    end
  end

  // ---------------- output side ----------------
  logic out_gated;
  logic out_paused;
  logic out_fire;
  logic out_last;
  assign out_gated = cfg_q.out_mode == tcs_pkg::TCS_TRIG_GATED;
  assign out_paused = out_gated && !out_trig.level;
  assign out_last = out_count_q != 32'h0000_0000 &&
    out_done_q + 32'h0000_0001 == out_count_q;

  // when every channel is updated
  always_comb begin
    out_fire = 1'b0;
    if (out_st_q == tcs_pkg::TCS_RUN) begin
      if (cfg_q.out_ext) begin
        // level sampled at each edge, so the gate width is free
        out_fire = ext_sync[1].change && !out_paused;
      end else begin
        out_fire = (out_gated && out_trig.rise) ||
          (!out_paused && out_timer_q == 32'h0000_0000);
      end
    end else if (out_st_q == tcs_pkg::TCS_ARM && !cfg_q.out_ext) begin
      out_fire = out_trig.level;
    end
  end

  // output sequencer state
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      out_st_q <= tcs_pkg::TCS_IDLE;
    end else if (wr_ctrl && i_wdata[`TCS_CTRL_OUT_STOP]) begin
      out_st_q <= tcs_pkg::TCS_IDLE;
    end else if (wr_ctrl && i_wdata[`TCS_CTRL_OUT_START]) begin
      out_st_q <= cfg_q.out_mode == tcs_pkg::TCS_TRIG_SINGLE ?
        tcs_pkg::TCS_ARM : tcs_pkg::TCS_RUN;
    end else if (out_fire && out_last) begin
      out_st_q <= tcs_pkg::TCS_IDLE;
    end else if (out_st_q == tcs_pkg::TCS_ARM && out_trig.level) begin
      out_st_q <= tcs_pkg::TCS_RUN;
    end
  end

  // update timer; halted while the gate is low
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      out_timer_q <= 32'h0000_0000;
    end else if (out_fire) begin
      out_timer_q <= out_period_q - 32'h0000_0001;
    end else if (out_timer_q != 32'h0000_0000 && !out_paused) begin
      out_timer_q <= out_timer_q - 32'h0000_0001;
    end
  end

  // update count
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      out_done_q <= 32'h0000_0000;
    end else if (wr_ctrl && i_wdata[`TCS_CTRL_OUT_START]) begin
      out_done_q <= 32'h0000_0000;
    end else if (out_fire) begin
      out_done_q <= out_done_q + 32'h0000_0001;
    end
  end

  // registered strobes; one load strobe serves all channels at once
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      in_sample_q <= 1'b0;
      out_update_q <= 1'b0;
    end else begin
      in_sample_q <= in_fire;
      out_update_q <= out_fire;
    end
  end

  assign o_rdata = rdata_q;
  assign o_in_sample = in_sample_q;
  assign o_in_chan = in_chan_q;
  assign o_out_update = out_update_q;

  // ---------------- checks ----------------
  sequence s_out_gate_low;
    out_st_q == tcs_pkg::TCS_RUN && out_gated && !cfg_q.out_ext &&
      !out_trig.level && !out_trig.rise;
  endsequence
  property p_out_gate_halt;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      s_out_gate_low |=> !o_out_update;
  endproperty
  a_out_gate_halt: assert property (p_out_gate_halt)
    else $error("output updated with gate low");

  property p_out_gate_restart;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      (out_st_q == tcs_pkg::TCS_RUN && out_gated && !cfg_q.out_ext &&
        out_trig.rise) |=> o_out_update;
  endproperty
  a_out_gate_restart: assert property (p_out_gate_restart)
    else $error("gate rise did not restart updates");

  property p_out_ext_first;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      (out_st_q == tcs_pkg::TCS_RUN && cfg_q.out_ext && out_trig.level &&
        ext_sync[1].change) |=> o_out_update;
  endproperty
  a_out_ext_first: assert property (p_out_ext_first)
    else $error("external output edge missed");

  property p_in_discard;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      (in_first_q && ext_sync[0].change && !wr_ctrl) ##1 !wr_ctrl |->
        !o_in_sample ##0 !in_first_q;
  endproperty
  a_in_discard: assert property (p_in_discard)
    else $error("first external input edge sampled");

  property p_in_second;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      (in_st_q == tcs_pkg::TCS_RUN && cfg_q.in_ext && !in_gated &&
        !in_first_q && ext_sync[0].change) |=> o_in_sample;
  endproperty
  a_in_second: assert property (p_in_second)
    else $error("second external input edge lost");

  property p_in_mid_list;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      (in_st_q == tcs_pkg::TCS_RUN && !cfg_q.in_ext && cfg_q.in_list &&
        in_chan_q != 4'h0 && in_timer_q == 32'h0000_0000) |=> o_in_sample;
  endproperty
  a_in_mid_list: assert property (p_in_mid_list)
    else $error("list cut short by low gate");

  property p_in_arm_hold;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      (in_st_q == tcs_pkg::TCS_ARM && !in_trig.level) |=> !o_in_sample;
  endproperty
  a_in_arm_hold: assert property (p_in_arm_hold)
    else $error("sample before single-shot trigger");

  sequence s_in_last;
    in_fire && in_last && !wr_ctrl;
  endsequence
  property p_in_count_end;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      s_in_last |=> o_in_sample && in_st_q == tcs_pkg::TCS_IDLE;
  endproperty
  a_in_count_end: assert property (p_in_count_end)
    else $error("input did not stop at count");

endmodule : tcs_trigger_clock_sequencer

`default_nettype wire

// *** tcs_ext_src.sv ***
`timescale 1ns/100ps
`default_nettype none

// far side: trigger pins and both link clocks; clocks stand low between
// bursts, so every edge the sequencer sees is one the bench asked for
module tcs_ext_src (
  output var logic o_in_ext_clk,
  output var logic o_out_ext_clk,
  output var logic o_in_trig,
  output var logic o_out_trig
);
  localparam int HALF_NS = 24; // half of the 48 ns link period
  localparam int SETUP_NS = 60; // slack above the 50 ns trigger setup

  // all pins quiet and low from time zero
  initial begin
    o_in_ext_clk = 1'b0;
    o_out_ext_clk = 1'b0;
    o_in_trig = 1'b0;
    o_out_trig = 1'b0;
  end

  // burst of n rising edges; the lead-in keeps trigger setup honoured
  task automatic edges(input bit outc, input int n);
    #(SETUP_NS);
    repeat (n) begin
      #(HALF_NS);
      if (outc) o_out_ext_clk = 1'b1;
      else o_in_ext_clk = 1'b1;
      #(HALF_NS);
      if (outc) o_out_ext_clk = 1'b0;
      else o_in_ext_clk = 1'b0;
    end
  endtask : edges

  // trigger level; the short lead keeps the change off the core clock edge
  task automatic trig(input bit outc, input bit lvl);
    #2;
    if (outc) o_out_trig = lvl;
    else o_in_trig = lvl;
  endtask : trig

  // gate pulse used as a sample clock: high 100 ns, inside 60..200 ns
  task automatic pulse_in();
    #2;
    o_in_trig = 1'b1;
    #100;
    o_in_trig = 1'b0;
    #100;
  endtask : pulse_in
endmodule : tcs_ext_src

`default_nettype wire

// *** tcs_trigger_clock_sequencer_tb_top.sv ***
`include "tcs_defs.svh"
`timescale 1ns/100ps
`default_nettype none

module tcs_trigger_clock_sequencer_tb_top;
  localparam logic [31:0] ONE = 32'h0000_0001;
  logic i_ref_clk, i_rst_n, i_wr, i_rd; // core clock and register strobes
  logic [3:0] i_addr;
  logic [31:0] i_wdata, o_rdata, v;
  logic in_clk, out_clk, in_trig, out_trig; // far-side pins
  logic o_in_sample, o_out_update;
  logic [3:0] o_in_chan;
  int fails, compares, n_in, n_out, lat;
  longint t_prev, t_last; // times of the last two output strobes

  tcs_ext_src tcs_ext_src_i (.o_in_ext_clk(in_clk), .o_out_ext_clk(out_clk),
    .o_in_trig(in_trig), .o_out_trig(out_trig));

  tcs_trigger_clock_sequencer tcs_trigger_clock_sequencer_i (
    .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_in_ext_clk(in_clk),
    .i_out_ext_clk(out_clk), .i_in_trig(in_trig), .i_out_trig(out_trig),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .o_in_sample(o_in_sample), .o_in_chan(o_in_chan),
    .o_out_update(o_out_update));

  // 100 MHz core clock
  initial begin
    i_ref_clk = 1'b0;
    forever #5 i_ref_clk = ~i_ref_clk;
  end

  // strobe counters sample mid-cycle so the bench can clear them on edges
  always @(negedge i_ref_clk) begin
    if (o_in_sample === 1'b1) n_in++;
    if (o_out_update === 1'b1) begin
      n_out++;
      t_prev = t_last;
      t_last = $time;
    end
  end

  task automatic print_verdict();
    if (fails == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge i_ref_clk);
  endtask : cyc

  // one-cycle write; release lands one edge before any next request
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
  endtask : wr

  // one-cycle read; data only stands in the cycle after the strobe
  task automatic rdc(input logic [3:0] a, input logic [31:0] exp);
    @(posedge i_ref_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    #1 v = o_rdata;
    chk(v, exp);
  endtask : rdc

  // clear counters, then start one direction with the given setup
  task automatic go(input logic [31:0] cfg, input logic [31:0] cmd);
    wr(`TCS_ADDR_CFG, cfg);
    n_in = 0;
    n_out = 0;
    wr(`TCS_ADDR_CTRL, cmd);
    #2;
  endtask : go

  // a hang anywhere ends the run as a mismatch
  initial begin
    #200000;
    fails++;
    print_verdict();
  end

  initial begin
    i_rst_n = 1'b0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = 4'h0;
    i_wdata = 32'h0000_0000;
    fails = 0;
    compares = 0;
    n_in = 0;
    n_out = 0;
    t_prev = 0;
    t_last = 0;
    // reset spans two ticks of each link clock for its own synchroniser
    fork
      tcs_ext_src_i.edges(1'b0, 2);
      tcs_ext_src_i.edges(1'b1, 2);
    join
    cyc(3);
    i_rst_n <= 1'b1;
    // the link reset flops swallow two more ticks after release
    fork
      tcs_ext_src_i.edges(1'b0, 2);
      tcs_ext_src_i.edges(1'b1, 2);
    join
    rdc(`TCS_ADDR_CFG, 32'h0000_0000);
    rdc(`TCS_ADDR_IN_PERIOD, 32'h0000_0064);
    rdc(`TCS_ADDR_LIST_LEN, 32'h0000_0001);
    rdc(`TCS_ADDR_STATUS, 32'h0000_0000);
    rdc(4'hf, 32'h0000_0000);
    // single-shot output: holds off while low, then runs to its count
    wr(`TCS_ADDR_OUT_PERIOD, 32'h0000_0005);
    wr(`TCS_ADDR_OUT_COUNT, 32'h0000_0003);
    go(32'h0000_0004, 32'h0000_0004);
    cyc(20);
    chk(n_out, 0);
    rdc(`TCS_ADDR_STATUS, 32'h0000_0008);
    @(posedge i_ref_clk);
    #2 tcs_ext_src_i.trig(1'b1, 1'b1);
    lat = 0;
    while (o_out_update !== 1'b1) begin
      @(posedge i_ref_clk);
      #1 lat++;
      if (lat > 20) begin
        fails++;
        print_verdict();
      end
    end
    chk(32'(lat >= 4 && lat <= 7), ONE);
    cyc(30);
    chk(n_out, 3);
    chk(32'(t_last - t_prev), 32'h0000_0032);
    rdc(`TCS_ADDR_OUT_DONE, 32'h0000_0003);
    rdc(`TCS_ADDR_STATUS, 32'h0000_0000);
    tcs_ext_src_i.trig(1'b1, 1'b0);
    // gated output, internal timer; 450 ns keeps clear of 100 ns multiples
    wr(`TCS_ADDR_OUT_COUNT, 32'h0000_0000);
    wr(`TCS_ADDR_OUT_PERIOD, 32'h0000_000a);
    go(32'h0000_0008, 32'h0000_0004);
    cyc(10);
    chk(n_out, 0);
    repeat (2) begin
      tcs_ext_src_i.trig(1'b1, 1'b1);
      #450 tcs_ext_src_i.trig(1'b1, 1'b0);
      cyc(30);
    end
    chk(n_out, 10);
    wr(`TCS_ADDR_CTRL, 32'h0000_0008);
    // gated output on the external clock: every edge updates all channels
    go(32'h0000_0028, 32'h0000_0004);
    tcs_ext_src_i.trig(1'b1, 1'b1);
    tcs_ext_src_i.edges(1'b1, 3);
    #30 tcs_ext_src_i.trig(1'b1, 1'b0);
    cyc(10);
    chk(n_out, 3);
    wr(`TCS_ADDR_CTRL, 32'h0000_0008);
    // external input clock: first edge only synchronises
    go(32'h0000_0010, 32'h0000_0001);
    tcs_ext_src_i.edges(1'b0, 4);
    cyc(10);
    chk(n_in, 3);
    wr(`TCS_ADDR_CTRL, 32'h0000_0002);
    // gate pulses as a sample clock, trigger low before start
    wr(`TCS_ADDR_IN_PERIOD, 32'h0000_03e8);
    go(32'h0000_0002, 32'h0000_0001);
    cyc(5);
    repeat (3) tcs_ext_src_i.pulse_in();
    cyc(10);
    chk(n_in, 3);
    wr(`TCS_ADDR_CTRL, 32'h0000_0002);
    // list clocking: a low gate only stops on a whole list
    wr(`TCS_ADDR_LIST_LEN, 32'h0000_0003);
    wr(`TCS_ADDR_IN_PERIOD, 32'h0000_0002);
    go(32'h0000_0042, 32'h0000_0001);
    tcs_ext_src_i.trig(1'b0, 1'b1);
    #130 tcs_ext_src_i.trig(1'b0, 1'b0);
    cyc(20);
    #1 chk(32'(o_in_chan), 32'h0000_0000);
    chk(32'(n_in % 3 == 0 && n_in > 0), ONE);
    wr(`TCS_ADDR_CTRL, 32'h0000_0002);
    // gate with external clock: first sample within two clock cycles
    wr(`TCS_ADDR_LIST_LEN, 32'h0000_0001);
    go(32'h0000_0012, 32'h0000_0001);
    tcs_ext_src_i.edges(1'b0, 1);
    cyc(5);
    tcs_ext_src_i.trig(1'b0, 1'b1);
    tcs_ext_src_i.edges(1'b0, 2);
    cyc(8);
    chk(32'(n_in >= 1 && n_in <= 2), ONE);
    lat = n_in;
    tcs_ext_src_i.trig(1'b0, 1'b0);
    cyc(10);
    tcs_ext_src_i.trig(1'b0, 1'b1);
    tcs_ext_src_i.edges(1'b0, 2);
    cyc(8);
    chk(32'(n_in - lat >= 1 && n_in - lat <= 2), ONE);
    tcs_ext_src_i.trig(1'b0, 1'b0);
    wr(`TCS_ADDR_CTRL, 32'h0000_0002);
    // single-shot input, internal timer: waits for the gate, stops at count
    wr(`TCS_ADDR_IN_PERIOD, 32'h0000_0003);
    wr(`TCS_ADDR_IN_COUNT, 32'h0000_0002);
    go(32'h0000_0001, 32'h0000_0001);
    cyc(10);
    chk(n_in, 0);
    rdc(`TCS_ADDR_STATUS, 32'h0000_0004);
    tcs_ext_src_i.trig(1'b0, 1'b1);
    cyc(20);
    chk(n_in, 2);
    rdc(`TCS_ADDR_IN_DONE, 32'h0000_0002);
    tcs_ext_src_i.trig(1'b0, 1'b0);
    rdc(`TCS_ADDR_STATUS, 32'h0000_0000);
    print_verdict();
  end
endmodule : tcs_trigger_clock_sequencer_tb_top

`default_nettype wire
